// >>> tsr_map.svh
// offsets, reset values, command codes and timing counts of the thermostat readout core
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
`define TSR_WORD_BITS 9
`define TSR_CMD_BITS 8
`define TSR_TEMP_RESET 9'h188
`define TSR_UPPER_FACTORY 9'h01E
`define TSR_LOWER_FACTORY 9'h014
`define TSR_TEMP_MIN 9'h192
`define TSR_TEMP_MAX 9'h0FA
`define TSR_CMD_RD_TEMP 8'hAA
`define TSR_CMD_RD_UPPER 8'hA1
`define TSR_CMD_RD_LOWER 8'hA2
`define TSR_CMD_WR_UPPER 8'h01
`define TSR_CMD_WR_LOWER 8'h02
`define TSR_CMD_START 8'hEE
`define TSR_CMD_LAST_BIT 5'h07
`define TSR_DATA_LAST_BIT 5'h10
`define TSR_BIT_CNT_MAX 5'h1F
`define TSR_CLK_HZ 40000000
`define TSR_CONVERT_START_N_TIME_MS 750
`define TSR_CONVERT_START_N_CYCLES ((`TSR_CONVERT_START_N_TIME_MS * (`TSR_CLK_HZ / 1000)))
`endif

// >>> tsr_pkg.sv
// types shared by the thermostat readout core
package tsr_pkg;
  typedef logic [8:0] tsr_word_t;
  typedef logic [7:0] tsr_cmd_t;
  typedef enum logic [1:0] {
    TSR_IDLE = 2'b01,
    TSR_CONVERT_START_N = 2'b10
  } tsr_state_t;
endpackage

// >>> tsr_core.sv
// thermostat readout core: three-wire serial port, conversion timing, trip outputs
// Overview of operation
// - over-limit high when temperature at or above upper
// - under-limit high when temperature at or below lower
// - hysteresis output sets at or above upper, clears at or below lower
// - stand-alone: convert starts on convert pin falling
// - temperature register read-only, resets to minus sixty
// - upper trip point read/write, factory plus fifteen
// - lower trip point read/write, factory plus ten
// - read-temperature command returns nine-bit reading
// - serial data moves least significant bit first
// - two-byte transfers allowed, upper seven bits ignored
// - zeros shifted out after most significant bit
// - one lsb equals half a degree
// - reading limited to minus 55 to 125
// - conversion completes within 750 milliseconds
// - short convert pulse gives exactly one conversion
// - one-shot outputs hold until next conversion
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_core #(
  parameter int unsigned CONVERT_START_N_CYCLES = `TSR_CONVERT_START_N_CYCLES
) (
  input wire logic clock, // system clock, 40 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic shift_clock_or_convert_in, // serial shift clock or convert_start_n
  input wire logic port_reset_n, // serial frame enable, low ends a frame
  input wire logic dq_in, // serial data line, level seen at the pin
  output logic dq_out, // serial data driven by the core
  output logic dq_oe, // high while the core drives the data line
  input wire logic cpu_mode, // high disables stand-alone convert use
  input wire tsr_pkg::tsr_word_t sensor_value, // raw reading from the sensor front end
  output logic convert_start_n_busy, // conversion in progress
  output logic over_limit_out, // temperature at or above upper trip point
  output logic under_limit_out, // temperature at or below lower trip point
  output logic hysteresis_out // combined trip output with hysteresis
);
  import tsr_pkg::*;

  // frame reset: link logic other than the write words is cleared whenever the host closes a frame
  logic link_rst_n;
  assign link_rst_n = rst_n & port_reset_n;

  // ---------------- link domain ----------------
  logic [4:0] bit_cnt_q;
  tsr_cmd_t cmd_q;
  tsr_word_t dat_q;
  tsr_word_t rd_sh_q;
  logic rd_act_q;
  logic rd_load;
  logic wr_tgl_q;
  tsr_cmd_t wr_cmd_q;
  tsr_word_t wr_dat_q;
  tsr_cmd_t cmd_full;
  tsr_word_t dat_full;
  tsr_word_t snap_temp_q;
  tsr_word_t snap_upper_q;
  tsr_word_t snap_lower_q;
  tsr_word_t rd_word;
  logic rd_hit;

  assign cmd_full = {dq_in, cmd_q[7:1]};
  assign dat_full = {dq_in, dat_q[8:1]};

  always_comb begin
    rd_hit = 1'b1;
    rd_word = snap_temp_q;
    unique case (cmd_full)
      `TSR_CMD_RD_TEMP: rd_word = snap_temp_q;
      `TSR_CMD_RD_UPPER: rd_word = snap_upper_q;
      `TSR_CMD_RD_LOWER: rd_word = snap_lower_q;
      default: rd_hit = 1'b0;
    endcase
  end

  assign rd_load = (bit_cnt_q == `TSR_CMD_LAST_BIT) && rd_hit;

  always_ff @(posedge shift_clock_or_convert_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != `TSR_BIT_CNT_MAX) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge shift_clock_or_convert_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cmd_q <= 8'h00;
      dat_q <= 9'h000;
    end else if (bit_cnt_q <= `TSR_CMD_LAST_BIT) begin
      cmd_q <= cmd_full;
    end else if (bit_cnt_q <= `TSR_DATA_LAST_BIT) begin
      dat_q <= dat_full;
    end
  end

  // read shifter: zero fill keeps the line low after the top bit
  always_ff @(posedge shift_clock_or_convert_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_sh_q <= 9'h000;
      rd_act_q <= 1'b0;
    end else if (rd_load) begin
      rd_sh_q <= rd_word;
      rd_act_q <= 1'b1;
    end else begin
      rd_sh_q <= {1'b0, rd_sh_q[8:1]};
    end
  end

  // write words stay held after the toggle, so the system side may read them
  always_ff @(posedge shift_clock_or_convert_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl_q <= 1'b0;
      wr_cmd_q <= 8'h00;
      wr_dat_q <= 9'h000;
    end else if (!port_reset_n) begin
      wr_tgl_q <= wr_tgl_q;
    end else if (bit_cnt_q == `TSR_CMD_LAST_BIT && cmd_full == `TSR_CMD_START) begin
      wr_cmd_q <= cmd_full;
      wr_tgl_q <= ~wr_tgl_q;
    end else if (bit_cnt_q == `TSR_DATA_LAST_BIT &&
                 (cmd_q == `TSR_CMD_WR_UPPER || cmd_q == `TSR_CMD_WR_LOWER)) begin
      wr_cmd_q <= cmd_q;
      wr_dat_q <= dat_full;
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // drive on the falling edge so the host samples a settled bit on the rising edge
  always_ff @(negedge shift_clock_or_convert_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dq_out <= 1'b0;
      dq_oe <= 1'b0;
    end else begin
      dq_out <= rd_sh_q[0];
      dq_oe <= rd_act_q;
    end
  end

  // ---------------- system domain ----------------
  logic frame_s1_q, frame_s2_q;
  logic convert_start_n_s1_q, convert_start_n_s2_q, convert_start_n_s3_q;
  logic cpu_s1_q, cpu_s2_q;
  logic wr_s1_q, wr_s2_q, wr_s3_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_s1_q <= 1'b0;
      frame_s2_q <= 1'b0;
      convert_start_n_s1_q <= 1'b1;
      convert_start_n_s2_q <= 1'b1;
      convert_start_n_s3_q <= 1'b1;
      cpu_s1_q <= 1'b0;
      cpu_s2_q <= 1'b0;
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else begin
      frame_s1_q <= port_reset_n;
      frame_s2_q <= frame_s1_q;
      convert_start_n_s1_q <= shift_clock_or_convert_in;
      convert_start_n_s2_q <= convert_start_n_s1_q;
      convert_start_n_s3_q <= convert_start_n_s2_q;
      cpu_s1_q <= cpu_mode;
      cpu_s2_q <= cpu_s1_q;
      wr_s1_q <= wr_tgl_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end

  logic standalone;
  logic std_fall;
  logic wr_evt;
  assign standalone = !cpu_s2_q && !frame_s2_q;
  assign std_fall = standalone && convert_start_n_s3_q && !convert_start_n_s2_q;
  assign wr_evt = wr_s2_q ^ wr_s3_q;

  tsr_word_t temp_q, upper_q, lower_q;
  tsr_state_t state_q;
  logic [31:0] convert_start_n_cnt_q;
  logic convert_start_n_done;
  logic start_req;
  tsr_word_t sample;

  // limit raw readings to the measurable span; one lsb is half a degree
  function automatic tsr_word_t tsr_clamp(input tsr_word_t v);
    tsr_word_t r;
    r = v;
    if ($signed(v) < $signed(`TSR_TEMP_MIN)) begin
      r = `TSR_TEMP_MIN;
    end else if ($signed(v) > $signed(`TSR_TEMP_MAX)) begin
      r = `TSR_TEMP_MAX;
    end
    return r;
  endfunction

  assign sample = tsr_clamp(sensor_value);
  assign convert_start_n_done = (state_q == TSR_CONVERT_START_N) && (convert_start_n_cnt_q == CONVERT_START_N_CYCLES - 32'd1);
  assign start_req = std_fall || (wr_evt && wr_cmd_q == `TSR_CMD_START);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TSR_IDLE;
      convert_start_n_cnt_q <= 32'd0;
    end else begin
      unique case (state_q)
        TSR_IDLE: begin
          convert_start_n_cnt_q <= 32'd0;
          if (start_req) begin
            state_q <= TSR_CONVERT_START_N;
          end
        end
        TSR_CONVERT_START_N: begin
          if (convert_start_n_done) begin
            convert_start_n_cnt_q <= 32'd0;
            // pin still low keeps converting; a short pulse gives just one
            if (!(standalone && !convert_start_n_s2_q)) begin
              state_q <= TSR_IDLE;
            end
          end else begin
            convert_start_n_cnt_q <= convert_start_n_cnt_q + 32'd1;
          end
        end
        default: state_q <= TSR_IDLE;
      endcase
    end
  end

  assign convert_start_n_busy = (state_q == TSR_CONVERT_START_N);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= `TSR_TEMP_RESET;
    end else if (convert_start_n_done) begin
      temp_q <= sample;
    end
  end

  // trip points model nonvolatile cells: reset restores the factory contents
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upper_q <= `TSR_UPPER_FACTORY;
      lower_q <= `TSR_LOWER_FACTORY;
    end else if (wr_evt) begin
      if (wr_cmd_q == `TSR_CMD_WR_UPPER) begin
        upper_q <= wr_dat_q;
      end
      if (wr_cmd_q == `TSR_CMD_WR_LOWER) begin
        lower_q <= wr_dat_q;
      end
    end
  end

  // snapshots freeze while a frame is open, so the link reads steady words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_temp_q <= `TSR_TEMP_RESET;
      snap_upper_q <= `TSR_UPPER_FACTORY;
      snap_lower_q <= `TSR_LOWER_FACTORY;
    end else if (!frame_s2_q) begin
      snap_temp_q <= temp_q;
      snap_upper_q <= upper_q;
      snap_lower_q <= lower_q;
    end
  end

  logic at_upper, at_lower;
  assign at_upper = $signed(sample) >= $signed(upper_q);
  assign at_lower = $signed(sample) <= $signed(lower_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      over_limit_out <= 1'b0;
      under_limit_out <= 1'b0;
      hysteresis_out <= 1'b0;
    end else if (convert_start_n_done) begin
      over_limit_out <= at_upper;
      under_limit_out <= at_lower;
      if (at_upper) begin
        hysteresis_out <= 1'b1;
      end else if (at_lower) begin
        hysteresis_out <= 1'b0;
      end
    end
  end

  // ---------------- assertions ----------------
  over_cmp_a: assert property (@(posedge clock) disable iff (!rst_n)
    convert_start_n_done |=> over_limit_out == ($signed($past(sample)) >= $signed($past(upper_q))))
    else $error("over-limit output disagrees with reading");

  under_cmp_a: assert property (@(posedge clock) disable iff (!rst_n)
    convert_start_n_done |=> under_limit_out == ($signed($past(sample)) <= $signed($past(lower_q))))
    else $error("under-limit output disagrees with reading");

  hyst_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    convert_start_n_done && !at_upper && at_lower |=> !hysteresis_out)
    else $error("hysteresis output not cleared at lower trip");

  hyst_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    convert_start_n_done && at_upper |=> hysteresis_out)
    else $error("hysteresis output not set at upper trip");

  convert_start_n_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == TSR_IDLE && std_fall |=> state_q == TSR_CONVERT_START_N && convert_start_n_cnt_q == 32'd0)
    else $error("convert pin fall did not start a conversion");

  temp_range_a: assert property (@(posedge clock) disable iff (!rst_n)
    temp_q == `TSR_TEMP_RESET ||
    ($signed(temp_q) >= $signed(`TSR_TEMP_MIN) && $signed(temp_q) <= $signed(`TSR_TEMP_MAX)))
    else $error("temperature outside measurable span");

  convert_start_n_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == TSR_CONVERT_START_N |-> convert_start_n_cnt_q < CONVERT_START_N_CYCLES)
    else $error("conversion ran past its time limit");

  outs_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !convert_start_n_done |=> $stable({over_limit_out, under_limit_out, hysteresis_out}) && $stable(temp_q))
    else $error("outputs changed without a conversion");

  one_shot_a: assert property (@(posedge clock) disable iff (!rst_n)
    convert_start_n_done && !cpu_s2_q && convert_start_n_s2_q |=> state_q == TSR_IDLE)
    else $error("short convert pulse gave more than one conversion");

  zero_tail_a: assert property (@(posedge shift_clock_or_convert_in)
    disable iff (!link_rst_n)
    rd_load |-> ##10 rd_sh_q == 9'h000)
    else $error("read shifter not empty after the top bit");

  cv_convert_start_n_c: cover property (@(posedge clock) disable iff (!rst_n) convert_start_n_done);
  cv_hyst_c: cover property (@(posedge clock) disable iff (!rst_n) $fell(hysteresis_out));
  cv_write_c: cover property (@(posedge clock) disable iff (!rst_n)
    wr_evt && wr_cmd_q == `TSR_CMD_WR_UPPER);
  cv_read_c: cover property (@(posedge shift_clock_or_convert_in)
    disable iff (!link_rst_n) rd_load && cmd_full == `TSR_CMD_RD_TEMP);
endmodule

// >>> tsr_host.sv
// host controller model for the three-wire port of the thermostat readout core
`timescale 1ns/1ps
module tsr_host (
  output logic port_reset_n, // frame enable to the core
  output logic shift_clk, // shift clock, also the convert pin
  output logic host_d, // level the host leaves on the data line
  input wire logic line // resolved data line level
);
  localparam int HALF = 16;
  initial begin
    port_reset_n = 1'b0;
    shift_clk = 1'b1;
    host_d = 1'b0;
  end
  // one frame; reply bits are gathered from shift edge 9 onward
  task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [8:0] wd,
      input int nbits, output logic [15:0] rd);
    rd = '0;
    port_reset_n = 1'b1; // frame opened, clock stays high until now
    #100;
    for (int i = 0; i < nbits; i++) begin
      shift_clk = 1'b0;
      if (i < 8) begin
        host_d = cmd[i]; // lsb first
      end else if (wr) begin
        host_d = (i < 17) ? wd[i-8] : 1'b0; // second byte top bits zero
      end else begin
        host_d = ~host_d; // released: no stale level to lean on
      end
      #HALF;
      shift_clk = 1'b1;
      if (i >= 8 && i < 24)
        rd[i-8] = line;
      #HALF;
    end
    port_reset_n = 1'b0; // may close right after the msb
    host_d = ~host_d;
    #100;
  endtask
  task automatic convert_pulse();
    shift_clk = 1'b0;
    #200; // ends well before the 20-cycle bench conversion, so one conversion only
    shift_clk = 1'b1;
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the thermostat readout core
`timescale 1ns/1ps
`include "tsr_map.svh"
module testbench;
  import tsr_pkg::*;
  localparam int CONVERT_START_N = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_mode = 1'b1;
  tsr_word_t sensor_value = '0;
  logic port_reset_n, shift_clk, host_d, dq_out, dq_oe, convert_start_n_busy, hyst, hi;
  logic over_limit_out, under_limit_out, hysteresis_out;
  wire logic dq_line = dq_oe ? dq_out : host_d;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] rd;
  tsr_word_t up, lo, t;
  tsr_word_t sens [6] = '{9'h032, 9'h000, 9'h1CE, 9'h000, 9'h0FF, 9'h180};
  tsr_core #(.CONVERT_START_N_CYCLES(CONVERT_START_N)) u_tsr_core (.clock(clock), .rst_n(rst_n),
    .shift_clock_or_convert_in(shift_clk), .port_reset_n(port_reset_n), .dq_in(dq_line),
    .dq_out(dq_out), .dq_oe(dq_oe), .cpu_mode(cpu_mode), .sensor_value(sensor_value),
    .convert_start_n_busy(convert_start_n_busy), .over_limit_out(over_limit_out),
    .under_limit_out(under_limit_out), .hysteresis_out(hysteresis_out));
  tsr_host u_tsr_host (.port_reset_n(port_reset_n), .shift_clk(shift_clk),
    .host_d(host_d), .line(dq_line));
  always #12.5 clock = ~clock;
  task automatic tally_and_finish();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic rd_chk(input tsr_cmd_t cmd, input tsr_word_t exp);
    tick(1);
    u_tsr_host.xfer(cmd, 1'b0, 9'h000, 24, rd);
    check(rd, {7'h00, exp}); // second byte all zeros after the msb
    check({15'h0000, dq_oe}, 16'h0000); // line let go once the frame closes
  endtask
  task automatic wr_reg(input tsr_cmd_t cmd, input tsr_word_t v, input int nbits);
    tick(1);
    u_tsr_host.xfer(cmd, 1'b1, v, nbits, rd);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (convert_start_n_busy !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    #2;
    check({15'h0000, convert_start_n_busy}, {15'h0000, lvl});
  endtask
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(3);
    rd_chk(`TSR_CMD_RD_TEMP, `TSR_TEMP_RESET);
    rd_chk(`TSR_CMD_RD_UPPER, `TSR_UPPER_FACTORY);
    rd_chk(`TSR_CMD_RD_LOWER, `TSR_LOWER_FACTORY);
    up = 9'h032;
    lo = 9'h1CE;
    wr_reg(`TSR_CMD_WR_UPPER, up, 17);
    wr_reg(`TSR_CMD_WR_LOWER, lo, 24);
    // closed one bit short, so this write must be dropped
    wr_reg(`TSR_CMD_WR_UPPER, 9'h1FF, 16);
    rd_chk(`TSR_CMD_RD_UPPER, up);
    rd_chk(`TSR_CMD_RD_LOWER, lo); // two-byte write form
    hyst = 1'b0;
    foreach (sens[i]) begin
      sensor_value = sens[i];
      if (i % 2 == 1) begin
        cpu_mode = 1'b0;
        tick(4);
        u_tsr_host.convert_pulse();
      end else begin
        wr_reg(`TSR_CMD_START, 9'h000, 8);
      end
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 30);
      if (i % 2 == 1) begin
        hi = 1'b0;
        repeat (50) begin
          tick(1);
          hi |= convert_start_n_busy;
        end
        check({15'h0000, hi}, 16'h0000);
      end
      tick(2);
      cpu_mode = 1'b1;
      t = sens[i];
      if ($signed(t) > $signed(`TSR_TEMP_MAX))
        t = `TSR_TEMP_MAX;
      if ($signed(t) < $signed(`TSR_TEMP_MIN))
        t = `TSR_TEMP_MIN;
      if ($signed(t) >= $signed(up))
        hyst = 1'b1;
      else if ($signed(t) <= $signed(lo))
        hyst = 1'b0;
      // raw input moves now; outputs must hold until the next conversion
      sensor_value = 9'h0F0;
      rd_chk(`TSR_CMD_RD_TEMP, t); // half-degree code read back
      check({15'h0000, over_limit_out}, {15'h0000, $signed(t) >= $signed(up)});
      check({15'h0000, under_limit_out}, {15'h0000, $signed(t) <= $signed(lo)});
      check({15'h0000, hysteresis_out}, {15'h0000, hyst});
    end
    tally_and_finish();
  end
endmodule
